/* dma_crc_pkg.sv */
// Constants shared by the DMA CRC engine and the channel control block.
// Holds definitions only; both design modules import it whole.
package dma_crc_pkg;
  localparam int          NUM_CH       = 8;
  localparam int          CH_W         = 3;
  localparam int          DW           = 32;
  localparam int          IP_W         = 16;
  localparam int          ADDR_LSB     = 2;

  // Register byte offsets.
  localparam logic [7:0]  OFS_CRC_CTRL = 8'h00;
  localparam logic [7:0]  OFS_CRC_VAL  = 8'h04;
  localparam logic [7:0]  OFS_CRC_MASK = 8'h08;
  localparam logic [7:0]  OFS_DST_STRT = 8'h0C;
  localparam logic [7:0]  OFS_PATTERN  = 8'h10;
  localparam logic [7:0]  OFS_CH_BASE  = 8'h20;
  localparam logic [7:0]  OFS_CH_END   = 8'h40;

  localparam logic [31:0] REG_RESET    = 32'h0000_0000;
  localparam logic [31:0] ALL_ONES     = 32'hFFFF_FFFF;
  localparam logic [4:0]  POLYNOMIAL_LENGTH_TOP     = 5'h1F;

  // crc_control fields and writable bits.
  localparam int          CC_BYTE_ORDER_SELECT      = 28;
  localparam int          CC_WBO       = 27;
  localparam int          CC_BIT_ORDER_SELECT      = 24;
  localparam int          CC_POLYNOMIAL_LENGTH      = 8;
  localparam int          CC_EN        = 7;
  localparam int          CC_APP       = 6;
  localparam int          CC_TYP       = 5;
  localparam int          CC_CH        = 0;
  localparam logic [31:0] CC_WMASK     = 32'h3900_1FE7;

  // channel_control fields and writable bits.
  localparam int          CH_IGN       = 24;
  localparam int          CH_BUSY      = 15;
  localparam int          CH_IGNEN     = 13;
  localparam int          CH_PATLEN    = 11;
  localparam int          CH_CHNS      = 8;
  localparam int          CH_EN        = 7;
  localparam int          CH_AED       = 6;
  localparam int          CH_CHN       = 5;
  localparam int          CH_EVT       = 2;
  localparam logic [31:0] CH_WMASK     = 32'hFF00_29E0;

  // Pattern setup register fields.
  localparam int          PAT_VAL      = 0;
  localparam int          PAT_EN       = 16;
  localparam logic [31:0] PAT_WMASK    = 32'h00FF_FFFF;

  // Byte order selections.
  localparam logic [1:0]  BO_NONE      = 2'h0;
  localparam logic [1:0]  BO_WORD_REV  = 2'h1;
  localparam logic [1:0]  BO_HALF_SWAP = 2'h2;
  localparam logic [1:0]  BO_HALF_BYTE = 2'h3;
endpackage

/* dma_crc_engine.sv */
// CRC engine: LFSR CRC of up to 32 bits or 16-bit header checksum.
// Expects one data word per feed pulse; seed and mode come from the top.
`timescale 1ns/100ps
module dma_crc_engine
  import dma_crc_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Configuration
  input  wire logic          ip_mode,
  input  wire logic          reflect,
  input  wire logic [4:0]    polynomial_length,
  input  wire logic [DW-1:0] mask,
  // Seed load and data feed
  input  wire logic          load,
  input  wire logic [DW-1:0] seed,
  input  wire logic          feed,
  input  wire logic [DW-1:0] data,
  // Result
  output logic      [DW-1:0] value
);
  logic [DW-1:0] acc;
  logic [DW-1:0] next_acc;
  logic [DW-1:0] rev;
  logic [DW-1:0] len_mask;

  genvar gi;
  for (gi = 0; gi < DW; gi++) begin : g_rev
    assign rev[gi] = data[DW-1-gi];
  end

  assign len_mask = ALL_ONES >> (POLYNOMIAL_LENGTH_TOP - polynomial_length);

  always_comb begin
    logic [DW-1:0]   c;
    logic [DW-1:0]   d;
    logic            fb;
    logic [IP_W+1:0] s;
    logic [IP_W:0]   s1;
    c        = acc;
    d        = reflect ? rev : data;
    fb       = 1'b0;
    s        = '0;
    s1       = '0;
    next_acc = acc;
    if (load) begin
      // The checksum is kept inverted so the read shows the ones-complement sum.
      next_acc = ip_mode ? {{IP_W{1'b0}}, ~seed[IP_W-1:0]} : seed & len_mask;
    end else if (feed && ip_mode) begin
      s        = (IP_W+2)'(acc[IP_W-1:0]) + (IP_W+2)'(d[IP_W-1:0])
               + (IP_W+2)'(d[DW-1:IP_W]);
      s1       = (IP_W+1)'(s[IP_W-1:0]) + (IP_W+1)'(s[IP_W+1:IP_W]);
      next_acc = {{IP_W{1'b0}}, s1[IP_W-1:0] + IP_W'(s1[IP_W])};
    end else if (feed) begin
      for (int i = 0; i < DW; i++) begin
        fb = c[polynomial_length] ^ d[DW-1-i];
        c  = ((c << 1) ^ (mask & {DW{fb}})) & len_mask;
      end
      next_acc = c;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) acc <= REG_RESET;
    else        acc <= next_acc;
  end

  assign value = ip_mode ? {{IP_W{1'b0}}, ~acc[IP_W-1:0]} : acc & len_mask;

  property p_ip_upper_zero;
    @(posedge clk) disable iff (!rst_n) ip_mode |-> value[DW-1:IP_W] == '0;
  endproperty
  a_ip_upper_zero: assert property (p_ip_upper_zero) else $error("checksum upper half set");

  property p_lfsr_len;
    @(posedge clk) disable iff (!rst_n) !ip_mode |-> (value & ~len_mask) == '0;
  endproperty
  a_lfsr_len: assert property (p_lfsr_len) else $error("crc bits above length set");

  property p_seed_load;
    @(posedge clk) disable iff (!rst_n)
      (load && !ip_mode) ##1 !ip_mode && $stable(polynomial_length) |-> value == ($past(seed) & len_mask);
  endproperty
  a_seed_load: assert property (p_seed_load) else $error("seed not returned");
endmodule

/* dma_crc_ctrl.sv */
// DMA CRC engine front end and per-channel control words for 8 channels.
// Assumes a same-clock register master, source stream and destination bus.
//
// Function
// - Append mode: CRC only, write CRC at end.
// - No append: pass data through, apply write ordering.
// - Type bit selects header checksum or LFSR.
// - Channel select binds CRC to one channel.
// - Reordered writing forbids setting append mode.
// - Polynomials up to 32 bits.
// - Data write seeds; read returns current CRC.
// - LFSR read zeroes bits above length.
// - Checksum mode: low 16 bits, ones-complement.
// - Mask bits enable feedback per stage.
// - Ignore byte matches as don't-care.
// - Ignore enable gates don't-care treatment.
// - Busy reads one while enabled or active.
// - Pattern length selects one or two bytes.
// - Chain direction picks higher or lower neighbour.
// - Disable suspends after in-flight transfer finishes.
// - Events recorded while disabled only if allowed.
// - Chain enable permits chained enabling.
// - CRC enable routes assigned channel through CRC.
// - Length field holds length minus one.
// - Bit order selects reflected computation.
// - Byte order field selects data reordering.
`timescale 1ns/100ps
module dma_crc_ctrl
  import dma_crc_pkg::*;
(
  // Clock and reset
  input  wire logic            CLK,
  input  wire logic            RST_N,
  // Register port
  input  wire logic [7:0]      ADDR,
  input  wire logic [DW-1:0]   WR_DATA,
  input  wire logic            WR_EN,
  input  wire logic            RD_EN,
  output logic      [DW-1:0]   RD_DATA,
  // Channel start and abort events
  input  wire logic [NUM_CH-1:0] START_EV,
  input  wire logic [NUM_CH-1:0] ABORT_EV,
  // Source words
  input  wire logic            SRC_VALID,
  output logic                 SRC_READY,
  input  wire logic [CH_W-1:0] SRC_CH,
  input  wire logic [DW-1:0]   SRC_DATA,
  input  wire logic [DW-1:0]   SRC_DADDR,
  input  wire logic            SRC_LAST,
  // Destination writes
  output logic                 DST_VALID,
  input  wire logic            DST_READY,
  output logic      [DW-1:0]   DST_ADDR,
  output logic      [DW-1:0]   DST_DATA,
  // Status
  output logic [NUM_CH-1:0]    CH_BUSY_OUT,
  output logic                 PAT_MATCH
);
  function automatic logic [DW-1:0] reorder(input logic [DW-1:0] d, input logic [1:0] sel);
    case (sel)
      BO_WORD_REV:  reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
      BO_HALF_SWAP: reorder = {d[15:0], d[31:16]};
      BO_HALF_BYTE: reorder = {d[23:16], d[31:24], d[7:0], d[15:8]};
      default:      reorder = d;
    endcase
  endfunction

  logic [DW-1:0]     cc;
  logic [DW-1:0]     next_cc;
  logic [DW-1:0]     mask;
  logic [DW-1:0]     next_mask;
  logic [DW-1:0]     dst_start;
  logic [DW-1:0]     next_dst_start;
  logic [DW-1:0]     pat;
  logic [DW-1:0]     next_pat;
  logic [DW-1:0]     crc_value;
  logic [DW-1:0]     rd_data;
  logic [DW-1:0]     next_rd_data;
  logic              dst_valid;
  logic              next_dst_valid;
  logic [DW-1:0]     dst_data;
  logic [DW-1:0]     next_dst_data;
  logic [DW-1:0]     dst_addr;
  logic [DW-1:0]     next_dst_addr;
  logic              app_pend;
  logic              next_app_pend;
  logic [CH_W-1:0]   fly_ch;
  logic [CH_W-1:0]   next_fly_ch;
  logic              pat_match;
  logic              next_pat_match;
  logic [NUM_CH-1:0] channel_enable_bit;
  logic [NUM_CH-1:0] busy;
  logic [NUM_CH-1:0] done_vec;
  logic [NUM_CH-1:0] match_vec;
  logic [NUM_CH-1:0] wr_ch;
  logic [DW-1:0]     ch_word [NUM_CH];
  logic [7:0]        ign_sel;
  logic              ignen_sel;
  logic              patlen_sel;
  logic              src_ready;
  logic              accept;
  logic              crc_route;
  logic              app;
  logic              match;
  logic              eq0;
  logic              eq1;
  logic              ch_hit;
  logic [CH_W-1:0]   ch_idx;
  logic [DW-1:0]     src_ordered;

  assign app         = cc[CC_APP];
  assign crc_route   = cc[CC_EN] && (SRC_CH == cc[CC_CH +: CH_W]);
  assign src_ready   = channel_enable_bit[SRC_CH] && !dst_valid && !app_pend;
  assign accept      = SRC_VALID && src_ready;
  assign src_ordered = reorder(SRC_DATA, cc[CC_BYTE_ORDER_SELECT +: 2]);
  assign ch_hit      = (ADDR >= OFS_CH_BASE) && (ADDR < OFS_CH_END) && (ADDR[1:0] == 2'h0);
  assign ch_idx      = CH_W'((ADDR - OFS_CH_BASE) >> ADDR_LSB);

  // Pattern compare on the accepted word, low byte first.
  assign ign_sel    = ch_word[SRC_CH][CH_IGN +: 8];
  assign ignen_sel  = ch_word[SRC_CH][CH_IGNEN];
  assign patlen_sel = ch_word[SRC_CH][CH_PATLEN];
  assign eq0        = (SRC_DATA[7:0] == pat[PAT_VAL +: 8])
                   || (ignen_sel && SRC_DATA[7:0] == ign_sel);
  assign eq1        = (SRC_DATA[15:8] == pat[PAT_VAL + 8 +: 8])
                   || (ignen_sel && SRC_DATA[15:8] == ign_sel);
  assign match      = pat[PAT_EN + SRC_CH] && eq0 && (!patlen_sel || eq1);

  assign done_vec   = (accept && SRC_LAST) ? NUM_CH'(1) << SRC_CH : '0;
  assign match_vec  = (accept && match) ? NUM_CH'(1) << SRC_CH : '0;

  // CRC configuration registers.
  always_comb begin
    next_cc        = cc;
    next_mask      = mask;
    next_dst_start = dst_start;
    next_pat       = pat;
    if (WR_EN && ADDR == OFS_CRC_CTRL) begin
      next_cc = WR_DATA & CC_WMASK;
      // Append cannot coexist with reordered destination writes.
      if (WR_DATA[CC_WBO]) next_cc[CC_APP] = 1'b0;
    end
    if (WR_EN && ADDR == OFS_CRC_MASK) next_mask      = WR_DATA;
    if (WR_EN && ADDR == OFS_DST_STRT) next_dst_start = WR_DATA;
    if (WR_EN && ADDR == OFS_PATTERN)  next_pat       = WR_DATA & PAT_WMASK;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cc        <= REG_RESET;
      mask      <= REG_RESET;
      dst_start <= REG_RESET;
      pat       <= REG_RESET;
    end else begin
      cc        <= next_cc;
      mask      <= next_mask;
      dst_start <= next_dst_start;
      pat       <= next_pat;
    end
  end

  dma_crc_engine u_engine (
    .clk     (CLK),
    .rst_n   (RST_N),
    .ip_mode (cc[CC_TYP]),
    .reflect (cc[CC_BIT_ORDER_SELECT]),
    .polynomial_length    (cc[CC_POLYNOMIAL_LENGTH +: 5]),
    .mask    (mask),
    .load    (WR_EN && ADDR == OFS_CRC_VAL),
    .seed    (WR_DATA),
    .feed    (accept && crc_route),
    .data    (src_ordered),
    .value   (crc_value)
  );

  // Per-channel control words.
  genvar c;
  for (c = 0; c < NUM_CH; c++) begin : g_ch
    logic [DW-1:0] cfg;
    logic [DW-1:0] next_cfg;
    logic          up_done;
    logic          dn_done;
    logic          chain_go;
    if (c == NUM_CH - 1) begin : g_top
      assign up_done = 1'b0;
    end else begin : g_up
      assign up_done = done_vec[c+1];
    end
    if (c == 0) begin : g_bot
      assign dn_done = 1'b0;
    end else begin : g_dn
      assign dn_done = done_vec[c-1];
    end
    assign wr_ch[c]   = WR_EN && ch_hit && (ch_idx == CH_W'(c));
    assign chain_go   = cfg[CH_CHN] && (cfg[CH_CHNS] ? up_done : dn_done);
    assign channel_enable_bit[c]    = cfg[CH_EN];
    assign busy[c]    = cfg[CH_EN] || ((dst_valid || app_pend) && fly_ch == CH_W'(c));
    assign ch_word[c] = cfg | (DW'(busy[c]) << CH_BUSY);

    always_comb begin
      next_cfg = cfg;
      if (wr_ch[c]) next_cfg = WR_DATA & CH_WMASK;
      if ((ABORT_EV[c] && cfg[CH_EN]) || done_vec[c] || match_vec[c]) next_cfg[CH_EN] = 1'b0;
      // Event capture beats a software write in the same cycle.
      if ((START_EV[c] || ABORT_EV[c]) && (cfg[CH_EN] || cfg[CH_AED])) next_cfg[CH_EVT] = 1'b1;
      if (chain_go) next_cfg[CH_EN] = 1'b1;
    end

    always_ff @(posedge CLK) begin
      if (!RST_N) cfg <= REG_RESET;
      else        cfg <= next_cfg;
    end
  end

  // Data path: one word in flight, or one pending CRC append write.
  always_comb begin
    next_dst_valid = dst_valid;
    next_dst_data  = dst_data;
    next_dst_addr  = dst_addr;
    next_app_pend  = app_pend;
    next_fly_ch    = fly_ch;
    next_pat_match = 1'b0;
    if (dst_valid && DST_READY) next_dst_valid = 1'b0;
    if (app_pend) begin
      // The engine has taken the last word by now, so its value is final.
      next_dst_valid = 1'b1;
      next_dst_data  = crc_value;
      next_dst_addr  = dst_start;
      next_app_pend  = 1'b0;
    end
    if (accept) begin
      next_fly_ch    = SRC_CH;
      next_pat_match = match;
      if (crc_route && app) begin
        next_app_pend = SRC_LAST;
      end else begin
        next_dst_valid = 1'b1;
        next_dst_addr  = SRC_DADDR;
        next_dst_data  = (crc_route && cc[CC_WBO]) ? src_ordered : SRC_DATA;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dst_valid <= 1'b0;
      dst_data  <= REG_RESET;
      dst_addr  <= REG_RESET;
      app_pend  <= 1'b0;
      fly_ch    <= '0;
      pat_match <= 1'b0;
    end else begin
      dst_valid <= next_dst_valid;
      dst_data  <= next_dst_data;
      dst_addr  <= next_dst_addr;
      app_pend  <= next_app_pend;
      fly_ch    <= next_fly_ch;
      pat_match <= next_pat_match;
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_comb begin
    next_rd_data = '0;
    if (RD_EN) begin
      case (ADDR)
        OFS_CRC_CTRL: next_rd_data = cc;
        OFS_CRC_VAL:  next_rd_data = crc_value;
        OFS_CRC_MASK: next_rd_data = mask;
        OFS_DST_STRT: next_rd_data = dst_start;
        OFS_PATTERN:  next_rd_data = pat;
        default:      next_rd_data = ch_hit ? ch_word[ch_idx] : '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) rd_data <= REG_RESET;
    else        rd_data <= next_rd_data;
  end

  assign RD_DATA     = rd_data;
  assign SRC_READY   = src_ready;
  assign DST_VALID   = dst_valid;
  assign DST_DATA    = dst_data;
  assign DST_ADDR    = dst_addr;
  assign CH_BUSY_OUT = busy;
  assign PAT_MATCH   = pat_match;

  sequence s_last_append;
    accept && crc_route && app && SRC_LAST;
  endsequence

  sequence s_crc_written;
    ##2 DST_VALID && DST_ADDR == dst_start;
  endsequence

  property p_append_write;
    @(posedge CLK) disable iff (!RST_N) s_last_append |-> s_crc_written;
  endproperty
  a_append_write: assert property (p_append_write) else $error("crc append write missing");

  property p_append_no_data;
    @(posedge CLK) disable iff (!RST_N) accept && crc_route && app |=> !DST_VALID;
  endproperty
  a_append_no_data: assert property (p_append_no_data) else $error("append wrote data");

  property p_pass_data;
    @(posedge CLK) disable iff (!RST_N)
      accept && !(crc_route && app) |=> DST_VALID
        && DST_DATA == (($past(crc_route) && $past(cc[CC_WBO])) ? $past(src_ordered)
                                                                : $past(SRC_DATA));
  endproperty
  a_pass_data: assert property (p_pass_data) else $error("destination data wrong");

  property p_no_app_wbo;
    @(posedge CLK) disable iff (!RST_N) cc[CC_WBO] |-> !cc[CC_APP];
  endproperty
  a_no_app_wbo: assert property (p_no_app_wbo) else $error("append set with reordering");

  property p_busy_enabled;
    @(posedge CLK) disable iff (!RST_N) (channel_enable_bit & ~CH_BUSY_OUT) == '0;
  endproperty
  a_busy_enabled: assert property (p_busy_enabled) else $error("enabled channel not busy");

  property p_busy_in_flight;
    @(posedge CLK) disable iff (!RST_N) DST_VALID |-> CH_BUSY_OUT[fly_ch];
  endproperty
  a_busy_in_flight: assert property (p_busy_in_flight) else $error("busy dropped early");

  property p_event_ignored;
    @(posedge CLK) disable iff (!RST_N)
      START_EV[0] && !ABORT_EV[0] && !channel_enable_bit[0] && !ch_word[0][CH_AED]
        && !ch_word[0][CH_EVT] |=> !ch_word[0][CH_EVT];
  endproperty
  a_event_ignored: assert property (p_event_ignored) else $error("event taken while off");

  property p_chain_up;
    @(posedge CLK) disable iff (!RST_N)
      done_vec[0] && ch_word[1][CH_CHN] && !ch_word[1][CH_CHNS] |=> channel_enable_bit[1];
  endproperty
  a_chain_up: assert property (p_chain_up) else $error("chained channel not enabled");

  property p_match_pulse;
    @(posedge CLK) disable iff (!RST_N) accept && match |=> PAT_MATCH ##1 !PAT_MATCH;
  endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("pattern match pulse wrong");
endmodule

/* dst_mem_model.sv */
// Destination side of the DMA: accepts word writes after a chosen stall.
// Assumes the same clock as the block and one write offered at a time.
`timescale 1ns/100ps
module dst_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write request from the block
  input  wire logic        dst_valid,
  input  wire logic [31:0] dst_addr,
  input  wire logic [31:0] dst_data,
  output logic             dst_ready,
  // Stall length and record of accepted writes
  input  wire logic [3:0]  delay,
  output logic [7:0]       wr_count,
  output logic [31:0]      last_addr,
  output logic [31:0]      last_data
);
  logic [3:0] cnt;

  // Ready only answers a pending write, so it never runs ahead of the request.
  assign dst_ready = dst_valid && (cnt >= delay);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt       <= 4'h0;
      wr_count  <= 8'h00;
      last_addr <= 32'h0000_0000;
      last_data <= 32'h0000_0000;
    end else if (dst_valid && dst_ready) begin
      cnt       <= 4'h0;
      wr_count  <= wr_count + 8'h01;
      last_addr <= dst_addr;
      last_data <= dst_data;
    end else if (dst_valid) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

/* testbench.sv */
// Self-checking bench for the DMA CRC and channel control block.
// Assumes one 100 MHz clock and a destination model that may stall.
`timescale 1ns/100ps
module testbench
  import dma_crc_pkg::*;
  ;
  logic        CLK, RST_N, WR_EN, RD_EN, SRC_VALID, SRC_READY, SRC_LAST;
  logic        DST_VALID, DST_READY, PAT_MATCH;
  logic [7:0]  ADDR, START_EV, ABORT_EV, CH_BUSY_OUT, wr_count;
  logic [31:0] WR_DATA, RD_DATA, SRC_DATA, SRC_DADDR, DST_ADDR, DST_DATA;
  logic [31:0] last_addr, last_data, crc;
  logic [2:0]  SRC_CH;
  logic [3:0]  delay;
  logic [31:0] swp [4];
  int          error_cnt, checks, cycles;

  dma_crc_ctrl u_dma_crc_ctrl (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .START_EV(START_EV),
    .ABORT_EV(ABORT_EV), .SRC_VALID(SRC_VALID), .SRC_READY(SRC_READY), .SRC_CH(SRC_CH),
    .SRC_DATA(SRC_DATA), .SRC_DADDR(SRC_DADDR), .SRC_LAST(SRC_LAST),
    .DST_VALID(DST_VALID), .DST_READY(DST_READY), .DST_ADDR(DST_ADDR),
    .DST_DATA(DST_DATA), .CH_BUSY_OUT(CH_BUSY_OUT), .PAT_MATCH(PAT_MATCH));

  dst_mem_model u_dst_mem_model (.clk(CLK), .rst_n(RST_N), .dst_valid(DST_VALID),
    .dst_addr(DST_ADDR), .dst_data(DST_DATA), .dst_ready(DST_READY), .delay(delay),
    .wr_count(wr_count), .last_addr(last_addr), .last_data(last_data));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // The whole run needs well under a thousand cycles.
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    WR_EN   <= 1'b1;
    ADDR    <= a;
    WR_DATA <= d;
    @(posedge CLK);
    WR_EN   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge CLK);
    RD_EN <= 1'b1;
    ADDR  <= a;
    @(posedge CLK);
    RD_EN <= 1'b0;
    @(negedge CLK);
    chk(n, e, RD_DATA);
  endtask

  // Returns at the edge that takes the word; ready is judged once settled.
  task automatic send(input logic [2:0] c, input logic [31:0] d, input logic l);
    @(posedge CLK);
    SRC_VALID <= 1'b1;
    SRC_CH    <= c;
    SRC_DATA  <= d;
    SRC_DADDR <= 32'h0000_0200;
    SRC_LAST  <= l;
    @(negedge CLK);
    while (SRC_READY !== 1'b1) @(negedge CLK);
    @(posedge CLK);
    SRC_VALID <= 1'b0;
  endtask

  task automatic wait_dst(input logic [7:0] n);
    while (wr_count !== n) @(negedge CLK);
  endtask

  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [31:0] w);
    logic fb;
    for (int i = 31; i >= 0; i--) begin
      fb = c[7] ^ w[i];
      c  = ((c << 1) ^ (32'h0000_0007 & {32{fb}})) & 32'h0000_00FF;
    end
    return c;
  endfunction

  initial begin
    {WR_EN, RD_EN, SRC_VALID, SRC_LAST} = 4'h0;
    {ADDR, START_EV, ABORT_EV} = 24'h00_0000;
    {WR_DATA, SRC_DATA, SRC_DADDR} = 96'h0;
    SRC_CH = 3'h0;
    delay  = 4'h0;
    swp    = '{32'h1122_3344, 32'h4433_2211, 32'h3344_1122, 32'h2211_4433};
    RST_N  = 1'b0;
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    chk("ready after reset", 32'h0, {SRC_READY, DST_VALID, PAT_MATCH, CH_BUSY_OUT});
    for (int i = 0; i < 5; i++) rd(8'(4 * i), REG_RESET, "reset value");
    rd(OFS_CH_BASE, REG_RESET, "channel reset");
    wr(8'h44, ALL_ONES);
    rd(8'h44, 32'h0, "unmapped");
    $display("test registers done");

    wr(OFS_CRC_CTRL, ALL_ONES);
    rd(OFS_CRC_CTRL, CC_WMASK & ~32'h0000_0040, "append refused");
    wr(OFS_CRC_CTRL, CC_WMASK & ~32'h0800_0000);
    rd(OFS_CRC_CTRL, CC_WMASK & ~32'h0800_0000, "control fields");
    wr(OFS_CH_BASE + 8'h1C, ALL_ONES);
    rd(OFS_CH_BASE + 8'h1C, CH_WMASK | 32'h0000_8000, "channel fields");
    wr(OFS_CH_BASE + 8'h1C, 32'h0);
    wr(OFS_CRC_CTRL, 32'h0000_0783);
    wr(OFS_CRC_VAL, ALL_ONES);
    rd(OFS_CRC_VAL, 32'h0000_00FF, "length masked");
    wr(OFS_CRC_CTRL, 32'h0000_0020);
    wr(OFS_CRC_VAL, 32'hABCD_1234);
    rd(OFS_CRC_VAL, 32'h0000_1234, "checksum seed");
    $display("test crc registers done");

    wr(OFS_CH_BASE + 8'h0C, 32'h0000_0080);
    wr(OFS_CRC_MASK, 32'h0000_0007);
    for (int b = 0; b < 4; b++) begin
      wr(OFS_CRC_CTRL, {2'b00, 2'(b), 28'h800_0783});
      wr(OFS_CRC_VAL, 32'h0);
      send(3'h3, swp[0], 1'b0);
      wait_dst(8'(b + 1));
      chk("reordered data", swp[b], last_data);
      chk("write address", 32'h0000_0200, last_addr);
      rd(OFS_CRC_VAL, crc8(32'h0, swp[b]), "crc of reordered");
    end
    $display("test byte order done");

    wr(OFS_CRC_CTRL, 32'h0000_07C3);
    wr(OFS_DST_STRT, 32'h0000_0100);
    wr(OFS_CRC_VAL, 32'h0000_005A);
    send(3'h3, 32'hC0FF_EE11, 1'b0);
    send(3'h3, 32'h0BAD_F00D, 1'b1);
    wait_dst(8'h05);
    crc = crc8(crc8(32'h0000_005A, 32'hC0FF_EE11), 32'h0BAD_F00D);
    chk("append address", 32'h0000_0100, last_addr);
    chk("append crc", crc, last_data);
    rd(OFS_CRC_VAL, crc, "crc after block");
    chk("no data written", 32'h5, 32'(wr_count));
    rd(OFS_CH_BASE + 8'h0C, 32'h0, "done clears busy");
    $display("test append done");

    wr(OFS_CRC_CTRL, 32'h0);
    wr(OFS_CH_BASE + 8'h0C, 32'h0000_0080);
    delay <= 4'h8;
    send(3'h3, 32'h1234_5678, 1'b0);
    wr(OFS_CH_BASE + 8'h0C, 32'h0);
    rd(OFS_CH_BASE + 8'h0C, 32'h0000_8000, "busy while in flight");
    chk("busy pin in flight", 32'h8, 32'(CH_BUSY_OUT));
    wait_dst(8'h06);
    @(negedge CLK);
    chk("suspended", 32'h0, 32'(CH_BUSY_OUT));
    delay <= 4'h0;
    $display("test suspend done");

    @(posedge CLK);
    START_EV <= 8'h01;
    @(posedge CLK);
    START_EV <= 8'h00;
    rd(OFS_CH_BASE, 32'h0, "event ignored");
    wr(OFS_CH_BASE, 32'h0000_0040);
    @(posedge CLK);
    ABORT_EV <= 8'h01;
    @(posedge CLK);
    ABORT_EV <= 8'h00;
    rd(OFS_CH_BASE, 32'h0000_0044, "event recorded");
    $display("test events done");

    wr(OFS_CH_BASE + 8'h04, 32'h0000_0020);
    wr(OFS_CH_BASE + 8'h08, 32'h0000_0120);
    wr(OFS_CH_BASE + 8'h10, 32'h0000_0800);
    wr(OFS_CH_BASE, 32'h0000_0080);
    send(3'h0, 32'h0000_0001, 1'b1);
    wait_dst(8'h07);
    rd(OFS_CH_BASE + 8'h04, 32'h0000_80A0, "chained from lower");
    rd(OFS_CH_BASE + 8'h08, 32'h0000_0120, "not chained");
    wr(OFS_CH_BASE + 8'h0C, 32'h0000_0080);
    send(3'h3, 32'h0000_0002, 1'b1);
    wait_dst(8'h08);
    rd(OFS_CH_BASE + 8'h08, 32'h0000_81A0, "chained from upper");
    // Channel 4 asks for its lower neighbour but has chaining off.
    rd(OFS_CH_BASE + 8'h10, 32'h0000_0800, "no chain enable");
    $display("test chaining done");

    wr(OFS_CRC_CTRL, 32'h0000_00A6);
    wr(OFS_CRC_VAL, 32'h0);
    wr(OFS_PATTERN, 32'h0040_BEEF);
    wr(OFS_CH_BASE + 8'h18, 32'h5500_2880);
    send(3'h6, 32'h0000_BE00, 1'b0);
    @(negedge CLK);
    chk("no match", 32'h0, 32'(PAT_MATCH));
    send(3'h6, 32'h0000_55EF, 1'b0);
    @(negedge CLK);
    chk("ignored byte match", 32'h1, 32'(PAT_MATCH));
    rd(OFS_CH_BASE + 8'h18, 32'h5500_2800, "match clears enable");
    // Ones-complement of 0xBE00 plus 0x55EF with the carry folded back.
    rd(OFS_CRC_VAL, 32'h0000_EC0F, "header checksum");
    wr(OFS_CRC_CTRL, 32'h0100_0783);
    wr(OFS_CRC_VAL, 32'h0);
    wr(OFS_CH_BASE + 8'h0C, 32'h0000_0080);
    send(3'h3, 32'h0000_0001, 1'b0);
    rd(OFS_CRC_VAL, crc8(32'h0, 32'h8000_0000), "reflected crc");
    $display("test pattern done");
    end_of_test();
  end
endmodule
